// *** rtl/qf_fetch_engine.sv ***
// per-queue descriptor fetch engine with context state
`include "qf_params.svh"
module qf_fetch_engine (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // global register writes
   input wire logic cfg_wr_i,
   input wire logic [11:0] cfg_addr_i,
   input wire logic [31:0] cfg_wdata_i,
   // indirect context bus
   input wire logic ctx_wr_i,
   input wire logic ctx_rd_i,
   input wire logic [3:0] ctx_sel_i,
   input wire logic [1:0] ctx_qid_i,
   input wire logic [63:0] ctx_wdata_i,
   output logic ctx_rvalid_o,
   output logic [63:0] ctx_rdata_o,
   // doorbells
   input wire logic host_to_card_doorbell_wr_i,
   input wire logic card_to_host_doorbell_wr_i,
   input wire logic [1:0] db_qid_i,
   input wire logic [31:0] db_wdata_i,
   output logic db_ready_o,
   // credit input
   input qf_pkg::qf_crd_in_t crd_i,
   output logic crd_ready_o,
   // descriptor read requests
   output logic rd_req_valid_o,
   output qf_pkg::qf_rd_req_t rd_req_o,
   input wire logic rd_req_ready_i,
   // read completions
   input wire logic cpl_valid_i,
   input qf_pkg::qf_dsc_t cpl_i,
   output logic cpl_ready_o,
   // descriptor delivery
   output logic eng_valid_o,
   input wire logic eng_ready_i,
   output logic byp_valid_o,
   input wire logic byp_ready_i,
   output qf_pkg::qf_dsc_t dsc_o,
   // descriptor completion
   input wire logic done_valid_i,
   input wire logic done_dir_i,
   input wire logic [1:0] done_qid_i,
   // status to user logic and host
   output logic tm_valid_o,
   output qf_pkg::qf_tm_t tm_o,
   input wire logic tm_ready_i,
   output logic stat_valid_o,
   output logic [2:0] stat_q_o,
   output logic irq_o,
   output logic [2:0] irq_q_o
);
   import qf_pkg::*;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [15:0] ring_sub(input logic [15:0] a, input logic [15:0] b,
                                            input logic [15:0] r);
      logic [16:0] s;
      s = (a >= b) ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, r} - {1'b0, b};
      return s[15:0];
   endfunction

   function automatic logic [15:0] ring_add(input logic [15:0] a, input logic [15:0] n,
                                            input logic [15:0] r);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, n};
      if (s >= {1'b0, r})
      begin
         s = s - {1'b0, r};
      end
      return s[15:0];
   endfunction

   function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
      return (a < b) ? a : b;
   endfunction

   function automatic logic [3:0] first_one(input logic [7:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 7; i >= 0; i--)
      begin
         if (v[i])
         begin
            r = {1'b1, 3'(i)};
         end
      end
      return r;
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [2:0] intvl_r;
   logic [15:0] ring_tab_r [16];
   logic [15:0] free_r [2];
   logic [63:0] sw_r [`QF_NCTX];
   logic [15:0] cidx_r [`QF_NCTX];
   logic [15:0] comp_r [`QF_NCTX];
   logic [15:0] used_r [`QF_NCTX];
   logic [15:0] credt_r [`QF_NCTX];
   logic [15:0] fence_r [`QF_NCTX];
   logic [15:0] icnt_r [`QF_NCTX];
   logic out_r [`QF_NCTX];
   logic act_r [`QF_NCTX];
   logic ipend_r [`QF_NCTX];
   logic req_v_r;
   qf_rd_req_t req_r;
   logic out_v_r;
   logic out_byp_r;
   qf_dsc_t out_dsc_r;
   logic tm_v_r;
   qf_tm_t tm_r;

   // ----------------------------------------
   // shared decode
   // ----------------------------------------
   logic [15:0] ring_w [`QF_NCTX];
   logic [15:0] avl_w [`QF_NCTX];
   logic [15:0] crd_w [`QF_NCTX];
   logic [15:0] cnt_w [`QF_NCTX];
   logic [7:0] elig_v, irqsel_v, qen_v, arm_v, fcrd_v, byp_v, stat_v;
   wire [11:0] ring_ofs = cfg_addr_i - `QF_RING_SZ_OFS;
   wire ring_hit = cfg_wr_i && ring_ofs < `QF_RING_SZ_SPAN && ring_ofs[1:0] == 2'h0;
   wire tm_free = !tm_v_r || tm_ready_i;
   wire db_any = host_to_card_doorbell_wr_i || card_to_host_doorbell_wr_i;
   wire db_dir = host_to_card_doorbell_wr_i ? `QF_DIR_H2C : `QF_DIR_C2H;
   wire db_acc = db_any && tm_free;
   wire [2:0] db_q = {db_dir, db_qid_i};
   wire crd_acc = crd_i.valid && crd_ready_o;
   wire [2:0] crd_q = {crd_i.dir, crd_i.qid};
   wire [3:0] sel_w = first_one(elig_v);
   wire [2:0] sel_q = sel_w[2:0];
   wire iss = sel_w[3] && (!req_v_r || rd_req_ready_i);
   wire [15:0] cnt_sel = cnt_w[sel_q];
   wire cpl_acc = cpl_valid_i && cpl_ready_o;
   wire [2:0] cpl_q = {cpl_i.dir, cpl_i.qid};
   wire cpl_byp = byp_v[cpl_q];
   wire take = out_v_r && (out_byp_r ? byp_ready_i : eng_ready_i);
   wire [2:0] ctx_q = {ctx_sel_i[0], ctx_qid_i};
   wire ctx_sw_wr = ctx_wr_i && ctx_sel_i[3:1] == `QF_SEL_SW;
   wire [3:0] irq_w = first_one(irqsel_v);
   wire irq_fire = irq_w[3];
   wire [2:0] irq_q = irq_w[2:0];
   wire [2:0] done_q = {done_dir_i, done_qid_i};
   wire [15:0] thr = 16'h0001 << intvl_r;
   wire db_arm_set = db_wdata_i[`QF_SW_ARM] && !arm_v[db_q];
   wire [15:0] db_avl = ring_sub(db_wdata_i[15:0], cidx_r[db_q], ring_w[db_q]);
   qf_hw_ctx_t hw_rd;
   qf_crd_ctx_t crd_rd;
   assign hw_rd = {1'b0, 3'h0, out_r[ctx_q], ipend_r[ctx_q], act_r[ctx_q],
                   comp_r[ctx_q] != sw_r[ctx_q][15:0], 8'h00, used_r[ctx_q],
                   cidx_r[ctx_q]};
   assign crd_rd = {16'h0000, credt_r[ctx_q]};
   wire [63:0] rd_mux = (ctx_sel_i[3:1] == `QF_SEL_SW) ? sw_r[ctx_q] :
                        (ctx_sel_i[3:1] == `QF_SEL_HW) ? {16'h0000, hw_rd} :
                        (ctx_sel_i[3:1] == `QF_SEL_CRD) ? {32'h0, crd_rd} : 64'h0;

   // ----------------------------------------
   // global registers
   // ----------------------------------------
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         intvl_r <= 3'h0;
      else if (cfg_wr_i && cfg_addr_i == `QF_GLBL_DSC_CFG_OFS)
         intvl_r <= cfg_wdata_i[2:0];
   end

   for (genvar k = 0; k < 16; k++)
   begin : g_ring
      always_ff @(posedge clk_i or posedge rst_i)
      begin
         if (rst_i)
            ring_tab_r[k] <= `QF_RING_SZ_RST;
         else if (ring_hit && ring_ofs[5:2] == 4'(k))
            ring_tab_r[k] <= cfg_wdata_i[15:0];
      end
   end

   for (genvar d = 0; d < 2; d++)
   begin : g_free
      wire [15:0] dec = (iss && sel_q[2] == 1'(d)) ? cnt_sel : 16'h0;
      wire [15:0] inc = (take && out_dsc_r.dir == 1'(d)) ? 16'h0001 : 16'h0;
      always_ff @(posedge clk_i or posedge rst_i)
      begin
         if (rst_i)
            free_r[d] <= `QF_CPL_ENTRIES;
         else
            free_r[d] <= free_r[d] - dec + inc;
      end
   end

   // ----------------------------------------
   // per-queue context
   // ----------------------------------------
   for (genvar q = 0; q < `QF_NCTX; q++)
   begin : g_q
      localparam logic [2:0] QI = 3'(q);
      wire [63:0] sw = sw_r[q];
      wire db_h = db_acc && db_q == QI;
      wire iss_h = iss && sel_q == QI;
      wire done_h = done_valid_i && done_q == QI;
      wire wr_h = ctx_sw_wr && ctx_q == QI;
      wire cpl_h = cpl_acc && cpl_i.last && cpl_q == QI;
      wire crd_h = crd_acc && crd_q == QI && sw[`QF_SW_QEN];
      wire irq_h = irq_fire && irq_q == QI;
      wire init_h = wr_h && ctx_wdata_i[`QF_SW_QEN] && !sw[`QF_SW_QEN];
      wire [15:0] comp_nxt = ring_add(comp_r[q], 16'h0001, ring_w[q]);
      wire [15:0] inc = icnt_r[q] + 16'h0001;
      wire intvl_ok = sw[`QF_SW_INTVL] && !sw[`QF_SW_BYP]
                      && !(QI[2] == `QF_DIR_C2H && sw[`QF_SW_STREAM]);
      wire [15:0] add_now = (crd_h && !crd_i.fence) ? crd_i.value : 16'h0;
      wire [15:0] add_fence = (crd_h && crd_i.fence) ? crd_i.value : 16'h0;
      assign ring_w[q] = ring_tab_r[sw[`QF_SW_RNG_HI:`QF_SW_RNG_LO]];
      assign avl_w[q] = ring_sub(sw[15:0], cidx_r[q], ring_w[q]);
      assign crd_w[q] = credt_r[q] - used_r[q];
      assign cnt_w[q] = min16(min16(avl_w[q], `QF_MRRS_DSC),
                              sw[`QF_SW_FCRD] ? crd_w[q] : 16'hffff);
      assign qen_v[q] = sw[`QF_SW_QEN];
      assign arm_v[q] = sw[`QF_SW_ARM];
      assign fcrd_v[q] = sw[`QF_SW_FCRD];
      assign byp_v[q] = sw[`QF_SW_BYP];
      assign elig_v[q] = sw[`QF_SW_QEN] && avl_w[q] != 16'h0
                         && (!sw[`QF_SW_FCRD] || crd_w[q] != 16'h0)
                         && !out_r[q]
                         && free_r[QI[2]] >= cnt_w[q];
      assign irqsel_v[q] = ipend_r[q] && sw[`QF_SW_ARM];
      assign stat_v[q] = done_h && !sw[`QF_SW_BYP]
                         && ((intvl_ok && inc == thr)
                         || (sw[`QF_SW_CHK] && comp_nxt == sw[15:0]));

      always_ff @(posedge clk_i or posedge rst_i)
      begin
         if (rst_i)
            sw_r[q] <= 64'h0;
         else if (wr_h)
            sw_r[q] <= ctx_wdata_i;
         else
         begin
            if (irq_h)
               sw_r[q][`QF_SW_ARM] <= 1'b0;
            if (db_h)
               sw_r[q][15:0] <= db_wdata_i[15:0];
            if (db_h && db_wdata_i[`QF_SW_ARM])
               sw_r[q][`QF_SW_ARM] <= 1'b1;
         end
      end

      always_ff @(posedge clk_i or posedge rst_i)
      begin
         if (rst_i)
         begin
            cidx_r[q] <= 16'h0;
            used_r[q] <= 16'h0;
            credt_r[q] <= 16'h0;
            fence_r[q] <= 16'h0;
            comp_r[q] <= 16'h0;
            icnt_r[q] <= 16'h0;
         end
         else if (init_h)
         begin
            cidx_r[q] <= 16'h0;
            used_r[q] <= 16'h0;
            credt_r[q] <= 16'h0;
            fence_r[q] <= 16'h0;
            comp_r[q] <= 16'h0;
            icnt_r[q] <= 16'h0;
         end
         else
         begin
            if (iss_h)
               cidx_r[q] <= ring_add(cidx_r[q], cnt_w[q], ring_w[q]);
            if (iss_h && sw[`QF_SW_FCRD])
               used_r[q] <= used_r[q] + cnt_w[q];
            credt_r[q] <= credt_r[q] + add_now + (iss_h ? fence_r[q] : 16'h0);
            fence_r[q] <= (iss_h ? 16'h0 : fence_r[q]) + add_fence;
            if (done_h)
               comp_r[q] <= comp_nxt;
            if (done_h && intvl_ok)
               icnt_r[q] <= (inc == thr) ? 16'h0 : inc;
         end
      end

      always_ff @(posedge clk_i or posedge rst_i)
      begin
         if (rst_i)
         begin
            out_r[q] <= 1'b0;
            act_r[q] <= 1'b0;
            ipend_r[q] <= 1'b0;
         end
         else
         begin
            out_r[q] <= iss_h || (out_r[q] && !cpl_h);
            act_r[q] <= sw[`QF_SW_QEN] || (act_r[q] && comp_r[q] != sw[15:0]);
            ipend_r[q] <= (ipend_r[q] && !irq_h) || (stat_v[q] && sw[`QF_SW_IRQ_EN]);
         end
      end

      active_set_a: assert property (
         @(posedge clk_i) disable iff (rst_i) qen_v[q] |=> act_r[q])
         else $error("active bit not set for enabled queue");
      fence_hold_a: assert property (
         @(posedge clk_i) disable iff (rst_i)
         crd_h && crd_i.fence && !iss_h && !init_h |=> credt_r[q] == $past(credt_r[q]))
         else $error("fenced credit added before request");
   end

   // ----------------------------------------
   // request, delivery and status
   // ----------------------------------------
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         req_v_r <= 1'b0;
         req_r <= '0;
      end
      else if (iss)
      begin
         req_v_r <= 1'b1;
         req_r <= {sel_q, cidx_r[sel_q], cnt_sel};
      end
      else if (rd_req_ready_i)
         req_v_r <= 1'b0;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         out_v_r <= 1'b0;
         out_byp_r <= 1'b0;
         out_dsc_r <= '0;
      end
      else if (cpl_acc)
      begin
         out_v_r <= 1'b1;
         out_byp_r <= cpl_byp;
         out_dsc_r <= cpl_i;
      end
      else if (take)
         out_v_r <= 1'b0;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         tm_v_r <= 1'b0;
         tm_r <= '0;
      end
      else if (db_acc)
      begin
         tm_v_r <= 1'b1;
         tm_r <= {db_q, db_avl, db_arm_set, !qen_v[db_q], byp_v[db_q]};
      end
      else if (crd_acc && !qen_v[crd_q])
      begin
         tm_v_r <= 1'b1;
         tm_r <= {crd_q, crd_i.value, 1'b0, 1'b1, byp_v[crd_q]};
      end
      else if (tm_ready_i)
         tm_v_r <= 1'b0;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         stat_valid_o <= 1'b0;
         stat_q_o <= 3'h0;
         irq_o <= 1'b0;
         irq_q_o <= 3'h0;
         ctx_rvalid_o <= 1'b0;
         ctx_rdata_o <= 64'h0;
      end
      else
      begin
         stat_valid_o <= |stat_v;
         stat_q_o <= done_q;
         irq_o <= irq_fire;
         irq_q_o <= irq_q;
         ctx_rvalid_o <= ctx_rd_i;
         ctx_rdata_o <= rd_mux;
      end
   end

   assign db_ready_o = tm_free;
   assign crd_ready_o = tm_free && !db_any;
   assign rd_req_valid_o = req_v_r;
   assign rd_req_o = req_r;
   assign cpl_ready_o = !out_v_r || take;
   assign eng_valid_o = out_v_r && !out_byp_r;
   assign byp_valid_o = out_v_r && out_byp_r;
   assign dsc_o = out_dsc_r;
   assign tm_valid_o = tm_v_r;
   assign tm_o = tm_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence req_stall_s;
      rd_req_valid_o && !rd_req_ready_i;
   endsequence

   req_hold_a: assert property (
      req_stall_s |=> rd_req_valid_o && $stable(rd_req_o))
      else $error("read request changed while stalled");
   fetch_gate_a: assert property (
      iss |-> qen_v[sel_q] && avl_w[sel_q] != 16'h0
              && (!fcrd_v[sel_q] || cnt_sel <= crd_w[sel_q]) && cnt_sel <= `QF_MRRS_DSC)
      else $error("fetch issued without descriptors or credits");
   one_out_a: assert property (
      iss |=> out_r[$past(sel_q)] && !(iss && sel_q == $past(sel_q)))
      else $error("second outstanding read for one queue");
   cpl_space_a: assert property (
      iss |-> free_r[sel_q[2]] >= cnt_sel && free_r[sel_q[2]] <= `QF_CPL_ENTRIES)
      else $error("fetch issued without completion room");
   irq_armed_a: assert property (
      irq_fire |-> arm_v[irq_q] ##1 irq_o && irq_q_o == $past(irq_q))
      else $error("interrupt from unarmed queue");
   irq_disarm_a: assert property (
      irq_fire && !db_any && !ctx_wr_i |=> !arm_v[$past(irq_q)])
      else $error("armed bit kept after interrupt");
   tm_hold_a: assert property (
      tm_valid_o && !tm_ready_i |=> tm_valid_o && $stable(tm_o))
      else $error("status changed while stalled");
   route_a: assert property (
      cpl_acc |=> byp_valid_o == $past(cpl_byp) && eng_valid_o == !$past(cpl_byp))
      else $error("descriptor sent to wrong port");
endmodule

// *** rtl/qf_params.svh ***
// constants for the queue descriptor fetch engine
`ifndef QF_PARAMS_SVH
`define QF_PARAMS_SVH
`define QF_NCTX 8
`define QF_DSC_W 256
`define QF_CPL_ENTRIES 16'h0100
`define QF_MRRS_DSC 16'h0010
`define QF_GLBL_DSC_CFG_OFS 12'h250
`define QF_RING_SZ_OFS 12'h204
`define QF_RING_SZ_SPAN 12'h040
`define QF_RING_SZ_RST 16'h0040
`define QF_DIR_C2H 1'b0
`define QF_DIR_H2C 1'b1
`define QF_SW_IRQ_EN 53
`define QF_SW_BYP 50
`define QF_SW_RNG_HI 47
`define QF_SW_RNG_LO 44
`define QF_SW_INTVL 35
`define QF_SW_CHK 34
`define QF_SW_FCRD 33
`define QF_SW_QEN 32
`define QF_SW_STREAM 25
`define QF_SW_ARM 16
`define QF_SEL_SW 3'h0
`define QF_SEL_HW 3'h1
`define QF_SEL_CRD 3'h2
`endif

// *** rtl/qf_pkg.sv ***
// types for the queue descriptor fetch engine
package qf_pkg;
`include "qf_params.svh"
   typedef struct packed {
      logic rsv_hi;
      logic [3:0] fetch_pnd;
      logic evt_pnd;
      logic active;
      logic dsc_pnd;
      logic [7:0] rsv_lo;
      logic [15:0] crd_use;
      logic [15:0] cidx;
   } qf_hw_ctx_t;
   typedef struct packed {
      logic [15:0] rsv;
      logic [15:0] credit;
   } qf_crd_ctx_t;
   typedef struct packed {
      logic valid;
      logic dir;
      logic [1:0] qid;
      logic [15:0] value;
      logic fence;
   } qf_crd_in_t;
   typedef struct packed {
      logic dir;
      logic [1:0] qid;
      logic [15:0] cidx;
      logic [15:0] count;
   } qf_rd_req_t;
   typedef struct packed {
      logic dir;
      logic [1:0] qid;
      logic [15:0] avl;
      logic irq_arm;
      logic qinv;
      logic bypass;
   } qf_tm_t;
   typedef struct packed {
      logic dir;
      logic [1:0] qid;
      logic last;
      logic [`QF_DSC_W-1:0] data;
   } qf_dsc_t;
endpackage

// *** bench/qf_host_model.sv ***
// host memory and user fabric partner of the fetch engine
module qf_host_model (
   // clock, reset, pacing
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic slow_i,
   // read requests and completions
   input wire logic rd_req_valid_i,
   input qf_pkg::qf_rd_req_t rd_req_i,
   output logic rd_req_ready_o,
   output logic cpl_valid_o,
   output qf_pkg::qf_dsc_t cpl_o,
   input wire logic cpl_ready_i,
   // descriptor sinks and completion
   input wire logic eng_valid_i,
   input wire logic byp_valid_i,
   input qf_pkg::qf_dsc_t dsc_i,
   output logic eng_ready_o,
   output logic byp_ready_o,
   output logic done_valid_o,
   output logic done_dir_o,
   output logic [1:0] done_qid_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import qf_pkg::*;
   qf_rd_req_t q[$];
   logic [15:0] beat_r;
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         q.delete();
         beat_r <= '0;
         {rd_req_ready_o, cpl_valid_o, eng_ready_o, byp_ready_o, done_valid_o} <= '0;
         cpl_o <= '0;
         {done_dir_o, done_qid_o} <= '0;
      end
      else
      begin
         rd_req_ready_o <= slow_i ? 1'($urandom) : 1'b1;
         eng_ready_o <= slow_i ? 1'($urandom) : 1'b1;
         byp_ready_o <= slow_i ? 1'($urandom) : 1'b1;
         if (rd_req_valid_i && rd_req_ready_o)
            q.push_back(rd_req_i);
         if ((!cpl_valid_o || cpl_ready_i) && q.size() != 0 && !(slow_i && $urandom_range(1) == 0))
         begin
            cpl_valid_o <= 1'b1;
            cpl_o <= '{dir: q[0].dir, qid: q[0].qid, last: (beat_r + 16'h1 == q[0].count),
               data: {240'h0, q[0].cidx + beat_r}};
            beat_r <= (beat_r + 16'h1 == q[0].count) ? 16'h0 : beat_r + 16'h1;
            if (beat_r + 16'h1 == q[0].count)
               void'(q.pop_front());
         end
         else if (!cpl_valid_o || cpl_ready_i)
         begin
            cpl_valid_o <= 1'b0;
            cpl_o.data <= ~cpl_o.data;
         end
         done_valid_o <= (eng_valid_i && eng_ready_o) || (byp_valid_i && byp_ready_o);
         done_dir_o <= dsc_i.dir;
         done_qid_o <= dsc_i.qid;
      end
   end
endmodule

// *** bench/queue_descriptor_fetch_engine_tb.sv ***
// self-checking bench for the fetch engine
module queue_descriptor_fetch_engine_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import qf_pkg::*;
   logic clk_i, rst_i, slow, cfg_wr_i, ctx_wr_i, ctx_rd_i, ctx_rvalid_o, db_ready_o;
   logic host_to_card_doorbell_wr_i, card_to_host_doorbell_wr_i, crd_ready_o, rd_req_valid_o;
   logic rd_req_ready_i, cpl_valid_i, cpl_ready_o, eng_valid_o, eng_ready_i, byp_valid_o;
   logic byp_ready_i, done_valid_i, done_dir_i, tm_valid_o, tm_ready_i, stat_valid_o;
   logic [11:0] cfg_addr_i;
   logic [31:0] cfg_wdata_i, db_wdata_i;
   logic [3:0] ctx_sel_i;
   logic [1:0] ctx_qid_i, db_qid_i, done_qid_i;
   logic [63:0] ctx_wdata_i, ctx_rdata_o, rd;
   logic [15:0] p, c;
   logic arm, irq_o;
   qf_crd_in_t crd_i;
   qf_rd_req_t rd_req_o, lreq;
   qf_dsc_t cpl_i, dsc_o;
   qf_tm_t tm_o;
   int mismatches, total_checks, nreq, neng, nbyp, nstat, nirq, cyc, n;
   qf_fetch_engine dut (.clk_i, .rst_i, .cfg_wr_i, .cfg_addr_i, .cfg_wdata_i, .ctx_wr_i,
      .ctx_rd_i, .ctx_sel_i, .ctx_qid_i, .ctx_wdata_i, .ctx_rvalid_o, .ctx_rdata_o,
      .host_to_card_doorbell_wr_i, .card_to_host_doorbell_wr_i, .db_qid_i, .db_wdata_i,
      .db_ready_o, .crd_i, .crd_ready_o, .rd_req_valid_o, .rd_req_o, .rd_req_ready_i,
      .cpl_valid_i, .cpl_i, .cpl_ready_o, .eng_valid_o, .eng_ready_i, .byp_valid_o,
      .byp_ready_i, .dsc_o, .done_valid_i, .done_dir_i, .done_qid_i, .tm_valid_o, .tm_o,
      .tm_ready_i, .stat_valid_o, .stat_q_o(), .irq_o, .irq_q_o());
   qf_host_model host (.clk_i, .rst_i, .slow_i(slow), .rd_req_valid_i(rd_req_valid_o),
      .rd_req_i(rd_req_o), .rd_req_ready_o(rd_req_ready_i), .cpl_valid_o(cpl_valid_i),
      .cpl_o(cpl_i), .cpl_ready_i(cpl_ready_o), .eng_valid_i(eng_valid_o),
      .byp_valid_i(byp_valid_o), .dsc_i(dsc_o), .eng_ready_o(eng_ready_i),
      .byp_ready_o(byp_ready_i), .done_valid_o(done_valid_i), .done_dir_o(done_dir_i),
      .done_qid_o(done_qid_i));
   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // traffic counters and run limit
   always @(posedge clk_i)
   begin
      cyc++;
      if (rd_req_valid_o === 1'b1 && rd_req_ready_i)
         lreq <= rd_req_o;
      nreq += int'(rd_req_valid_o && rd_req_ready_i);
      neng += int'(eng_valid_o && eng_ready_i);
      nbyp += int'(byp_valid_o && byp_ready_i);
      nstat += int'(stat_valid_o);
      nirq += int'(irq_o);
      if (cyc == 40000)
      begin
         mismatches++;
         conclude();
      end
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (mismatches == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic tk(input int k);
      repeat (k) @(negedge clk_i);
   endtask
   task automatic cfg(input logic [11:0] a, input logic [31:0] d);
      cfg_wr_i = 1'b1;
      cfg_addr_i = a;
      cfg_wdata_i = d;
      tk(1);
      cfg_wr_i = 1'b0;
      tk(1);
   endtask
   task automatic ctx(input logic w, input logic [3:0] s, input logic [1:0] q, input logic [63:0] d);
      ctx_wr_i = w;
      ctx_rd_i = !w;
      ctx_sel_i = s;
      ctx_qid_i = q;
      ctx_wdata_i = d;
      tk(1);
      {ctx_wr_i, ctx_rd_i} = 2'b00;
      rd = ctx_rdata_o;
      chk(ctx_rvalid_o, !w);
      tk(1);
   endtask
   task automatic db(input logic h, input logic [1:0] q, input logic [15:0] pi, input logic [15:0] av,
      input logic inv);
      host_to_card_doorbell_wr_i = h;
      card_to_host_doorbell_wr_i = !h;
      db_qid_i = q;
      db_wdata_i = {15'h0, arm, pi};
      tk(1);
      {host_to_card_doorbell_wr_i, card_to_host_doorbell_wr_i} = 2'b00;
      chk({tm_valid_o, tm_o.dir, tm_o.qid, tm_o.avl, tm_o.qinv, tm_o.irq_arm},
         {1'b1, h, q, av, inv, arm});
   endtask
   task automatic crd(input logic [1:0] q, input logic [15:0] v, input logic f);
      crd_i = '{valid: 1'b1, dir: 1'b0, qid: q, value: v, fence: f};
      tk(1);
      crd_i.valid = 1'b0;
   endtask
   task automatic wreq(input int k);
      for (int i = 0; i < 400 && nreq < k; i++)
         tk(1);
   endtask
   task automatic whw(input logic [3:0] s, input logic [1:0] q, input logic [15:0] ci, input logic pnd);
      for (int i = 0; i < 1000; i++)
      begin
         ctx(1'b0, s, q, 64'h0);
         if (rd[15:0] === ci && rd[46:43] === 4'h0 && rd[40] === pnd)
            break;
      end
   endtask
   function automatic logic [63:0] sw(input logic byp, input logic [3:0] rng, input logic fcrd);
      return {13'h0, byp, 2'h0, rng, 8'h0, 1'b1, 1'b1, fcrd, 1'b1, 32'h0};
   endfunction
   function automatic logic [63:0] hw(input logic a, input logic pd, input logic [15:0] u,
      input logic [15:0] ci);
      return {22'h0, a, pd, 8'h0, u, ci};
   endfunction
   function automatic logic [15:0] avl(input logic [15:0] pi, input logic [15:0] ci);
      return (pi + 16'd64 - ci) % 16'd64;
   endfunction
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      {cfg_wr_i, ctx_wr_i, ctx_rd_i, host_to_card_doorbell_wr_i, card_to_host_doorbell_wr_i} = '0;
      {cfg_addr_i, cfg_wdata_i, ctx_sel_i, ctx_qid_i, ctx_wdata_i, db_qid_i, db_wdata_i} = '0;
      {slow, arm, crd_i, tm_ready_i} = 1'b1;
      rst_i = 1'b1;
      void'($urandom(32'hf0d3923e));
      tk(6);
      rst_i = 1'b0;
      ctx(1'b0, 4'h3, 2'd0, 64'h0);
      chk(rd, 64'h0);
      ctx(1'b0, 4'h5, 2'd0, 64'h0);
      chk(rd, 64'h0);
      cfg(12'h250, 32'h1);
      cfg(12'h208, 32'h10);
      cfg(12'h2a0, 32'h3);
      ctx(1'b1, 4'h1, 2'd0, sw(1'b0, 4'h1, 1'b0));
      ctx(1'b0, 4'h3, 2'd0, 64'h0);
      chk(rd, hw(1'b1, 1'b0, 16'h0, 16'h0));
      n = nstat;
      db(1'b1, 2'd0, 16'd10, 16'd10, 1'b0);
      wreq(1);
      chk(lreq, {1'b1, 2'd0, 16'd0, 16'd10});
      whw(4'h3, 2'd0, 16'd10, 1'b0);
      chk(rd, hw(1'b1, 1'b0, 16'h0, 16'd10));
      chk(nstat - n, 5);
      db(1'b1, 2'd0, 16'd3, 16'd9, 1'b0);
      wreq(2);
      chk(lreq, {1'b1, 2'd0, 16'd10, 16'd9});
      whw(4'h3, 2'd0, 16'd3, 1'b0);
      chk(neng, 19);
      ctx(1'b1, 4'h1, 2'd1, sw(1'b0, 4'h0, 1'b0));
      n = nreq;
      db(1'b1, 2'd1, 16'd40, 16'd40, 1'b0);
      wreq(n + 1);
      chk(lreq.count, 16'd16);
      whw(4'h3, 2'd1, 16'd40, 1'b0);
      chk(nreq - n, 3);
      ctx(1'b1, 4'h0, 2'd2, sw(1'b0, 4'h0, 1'b1));
      n = nreq;
      db(1'b0, 2'd2, 16'd20, 16'd20, 1'b0);
      tk(40);
      chk(nreq - n, 0);
      crd(2'd2, 16'd3, 1'b0);
      whw(4'h2, 2'd2, 16'd3, 1'b1);
      chk(lreq.count, 16'd3);
      chk(rd, hw(1'b1, 1'b1, 16'd3, 16'd3));
      crd(2'd2, 16'd4, 1'b1);
      ctx(1'b0, 4'h4, 2'd2, 64'h0);
      chk(rd, 64'd3);
      crd(2'd2, 16'd1, 1'b0);
      whw(4'h2, 2'd2, 16'd8, 1'b1);
      chk(rd[31:0], {16'd8, 16'd8});
      ctx(1'b0, 4'h4, 2'd2, 64'h0);
      chk(rd, 64'd8);
      crd(2'd3, 16'd7, 1'b0);
      chk({tm_valid_o, tm_o.qinv, tm_o.avl}, {1'b1, 1'b1, 16'd7});
      n = nreq;
      db(1'b0, 2'd3, 16'd5, 16'd5, 1'b1);
      tk(40);
      chk(nreq - n, 0);
      n = neng;
      c = nbyp[15:0];
      ctx(1'b1, 4'h0, 2'd0, sw(1'b1, 4'h0, 1'b0));
      db(1'b0, 2'd0, 16'd4, 16'd4, 1'b0);
      whw(4'h2, 2'd0, 16'd4, 1'b0);
      chk(nbyp[15:0] - c, 16'd4);
      chk(neng - n, 0);
      ctx(1'b1, 4'h1, 2'd2, sw(1'b0, 4'h0, 1'b0) | 64'h0020_0000_0000_0000);
      db(1'b1, 2'd2, 16'd4, 16'd4, 1'b0);
      whw(4'h3, 2'd2, 16'd4, 1'b0);
      chk({nirq, rd[42]}, {32'd0, 1'b1});
      arm = 1'b1;
      db(1'b1, 2'd2, 16'd6, 16'd2, 1'b0);
      arm = 1'b0;
      whw(4'h3, 2'd2, 16'd6, 1'b0);
      chk({nirq, rd[42]}, {32'd1, 1'b1});
      ctx(1'b0, 4'h1, 2'd2, 64'h0);
      chk(rd[16:0], 17'h00006);
      slow = 1'b1;
      p = 16'd40;
      repeat (6)
      begin
         c = p;
         p = (p + 16'($urandom_range(60) + 1)) % 16'd64;
         if (p == 16'd63)
            p = 16'd0;
         tm_ready_i = 1'b0;
         db(1'b1, 2'd1, p, avl(p, c), 1'b0);
         tk(1);
         chk({tm_valid_o, db_ready_o, crd_ready_o, tm_o.avl}, {3'b100, avl(p, c)});
         tm_ready_i = 1'b1;
         whw(4'h3, 2'd1, p, 1'b0);
         chk(rd[15:0], p);
      end
      conclude();
   end
endmodule
